// ==== hw/pss_pkg.sv ====
// Shared constants and types of the pressure sensor measurement sequencer.
// Assumes a 250 MHz clock; register offsets are byte addresses on Avalon-MM.
package pss_pkg;

	localparam int unsigned CLK_MHZ = 250;

	// Register byte offsets.
	localparam logic [7:0] ADR_STATUS = 8'h00;
	localparam logic [7:0] ADR_PWR    = 8'h04;
	localparam logic [7:0] ADR_OSR    = 8'h08;
	localparam logic [7:0] ADR_ODR    = 8'h0c;
	localparam logic [7:0] ADR_CFG    = 8'h10;
	localparam logic [7:0] ADR_PRESS  = 8'h14;
	localparam logic [7:0] ADR_TEMP   = 8'h18;
	localparam logic [7:0] ADR_CMD    = 8'h1c;

	// Field positions.
	localparam int unsigned PWR_PRESS_BIT = 0;
	localparam int unsigned PWR_TEMP_BIT  = 1;
	localparam int unsigned PWR_MODE_LSB  = 4;
	localparam int unsigned OSR_P_LSB     = 0;
	localparam int unsigned OSR_T_LSB     = 3;
	localparam int unsigned STAT_POR_BIT  = 0;
	localparam int unsigned STAT_MODE_LSB = 1;
	localparam int unsigned STAT_BUSY_BIT = 3;
	localparam int unsigned STAT_PEND_BIT = 4;

	// Reset values.
	localparam logic [1:0] PWR_RST = 2'h0;
	localparam logic [5:0] OSR_RST = 6'h00;
	localparam logic [4:0] ODR_RST = 5'h00;
	localparam logic [6:0] CFG_RST = 7'h00;
	localparam logic       POR_RST = 1'b1;

	// Soft reset command code.
	localparam logic [7:0] SOFT_RST_CMD = 8'h5a;

	// Oversampling and data widths.
	localparam logic [2:0] OSR_MAX = 3'h5;
	localparam int unsigned ADC_W  = 16;
	localparam int unsigned RES_W  = 21;

	// Timing: one conversion, and the base sample period of 1 / 200 Hz.
	localparam int unsigned CONV_TIME_NS    = 2000;
	localparam int unsigned CONV_CYC        = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned BASE_PERIOD_NS  = 5000000;
	localparam int unsigned BASE_PERIOD_CYC = BASE_PERIOD_NS / 1000 * CLK_MHZ;

	typedef enum logic [1:0] {
		M_SLEEP  = 2'b00,
		M_FORCED = 2'b01,
		M_NORMAL = 2'b11
	} pss_mode_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_TEMP = 3'b001,
		S_PRES = 3'b010,
		S_DONE = 3'b011
	} pss_seq_t;

	typedef struct packed {
		logic [7:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
	} pss_avm_req_t;

	typedef struct packed {
		logic [ADC_W-1:0] temp;
		logic [ADC_W-1:0] press;
	} pss_adc_t;

endpackage

// ==== hw/pss_sequencer.sv ====
// Power-mode controller, measurement sequencer and IIR stage of the sensor.
// Assumes ADC samples are valid whenever sampled and an Avalon-MM master.
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

// Summary of operation
// - Reset clears logic and registers except the power-on flag; device then sleeps.
// - Power-on flag set after any reset, cleared by reading it.
// - Mode field: 00 sleep, 01 or 10 forced, 11 normal.
// - Sleep starts no conversions; registers stay accessible.
// - Forced runs one measurement, stores results, returns to sleep.
// - Normal repeats measurement plus standby; period is prescaler over 200 Hz.
// - Normal keeps refreshing data registers without host writes.
// - Mode write during a measurement is held until the measurement ends.
// - While a change is pending, further mode writes are discarded.
// - Unsupported mode transitions are ignored; mode stays unchanged.
// - Period holds enabled temperature and pressure conversions, own oversampling.
// - Results pass the IIR stage when enabled, else unchanged.
// - Pressure converted only when power control bit 0 is set.
// - Pressure oversampling in bits 2:0, codes 000..101 give x1..x32.
// - Each doubling adds a bit, 16 to 21; extras in extended low byte.
// - Pressure and temperature oversampling independent, up to 32.
// - Smoothing coefficient from 0 (off) up to 127.
// - Temperature only when bit 1 set; oversampling in bits 5:3.
// - Filter reset on filter write, enable fall, or sleep to normal, except for a channel storing a result that cycle.
// - After filter reset or enable, first sample passes and seeds memory.
module pss_sequencer
	import pss_pkg::*;
#(
	parameter int unsigned BASE_CYC = pss_pkg::BASE_PERIOD_CYC
) (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// Register bus
	input  wire pss_pkg::pss_avm_req_t avm_req,
	output logic [31:0]                avm_readdata,
	output logic                       avm_waitrequest,
	// Converter samples
	input  wire pss_pkg::pss_adc_t     adc_smp,
	// Status
	output logic                       meas_active
);

	import pss_pkg::*;
	logic                 ack_ff;
	logic [31:0]          rdata_ff;
	logic [1:0]           pwr_ff;
	logic [5:0]           osr_ff;
	logic [4:0]           odr_ff;
	logic [6:0]           cfg_ff;
	logic                 por_ff;
	logic                 soft_ff;
	pss_mode_t            mode_ff, nxt_mode, pmode_ff, nxt_pmode, tgt;
	logic                 pend_ff, nxt_pend;
	pss_seq_t             seq_ff;
	logic [39:0]          tmr_ff;
	logic [RES_W-1:0]     acc_ff, sum, scaled, raw_t_ff, raw_p_ff, temp_ff, press_ff;
	logic [15:0]          tick_ff;
	logic [5:0]           smp_ff;
	logic                 fv_t_ff, fv_p_ff;
	logic                 wr_ok, rd_ok, wr_pwr, wr_cfg, busy, start, done;
	logic [1:0]           new_en;
	logic                 clr_all;
	logic [2:0]           cur_osr;
	logic                 cur_en;
	logic [ADC_W-1:0]     cur_smp;

	function automatic logic [2:0] eff_osr(input logic [2:0] c);
		return (c > OSR_MAX) ? OSR_MAX : c;
	endfunction

	function automatic logic [RES_W-1:0] iir(input logic [RES_W-1:0] old_v,
		input logic [RES_W-1:0] new_v, input logic [6:0] c);
		logic [28:0] num;
		num = 29'(old_v) * 29'(c) + 29'(new_v);
		return RES_W'(num / (29'(c) + 29'd1));
	endfunction

////////////////////////////////////////////////////////////////////////////////
// Bus slave: one wait cycle, then the access is taken.
	assign avm_waitrequest = (avm_req.read | avm_req.write) & ~ack_ff;
	assign wr_ok           = avm_req.write & ack_ff;
	assign rd_ok           = avm_req.read & ack_ff;
	assign wr_pwr          = wr_ok & (avm_req.address == ADR_PWR);
	assign wr_cfg          = wr_ok & (avm_req.address == ADR_CFG);
	assign avm_readdata    = rdata_ff;
	assign new_en          = avm_req.writedata[1:0];
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			ack_ff <= 1'b0;
		else
			ack_ff <= (avm_req.read | avm_req.write) & ~ack_ff;
	end
	// Read data is latched in the wait cycle so it stands at the accept edge.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_ff <= 32'h0;
		end else if (avm_req.read & ~ack_ff) begin
			case (avm_req.address)
				ADR_STATUS: rdata_ff <= {27'h0, pend_ff, busy, mode_ff, por_ff};
				ADR_PWR:    rdata_ff <= {26'h0, mode_ff, 2'h0, pwr_ff};
				ADR_OSR:    rdata_ff <= {26'h0, osr_ff};
				ADR_ODR:    rdata_ff <= {27'h0, odr_ff};
				ADR_CFG:    rdata_ff <= {25'h0, cfg_ff};
				ADR_PRESS:  rdata_ff <= {8'h0, press_ff, 3'h0};
				ADR_TEMP:   rdata_ff <= {8'h0, temp_ff, 3'h0};
				default:    rdata_ff <= 32'h0;
			endcase
		end
	end
	// Configuration stays writable in every mode.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pwr_ff <= PWR_RST;
			osr_ff <= OSR_RST;
			odr_ff <= ODR_RST;
			cfg_ff <= CFG_RST;
		end else if (soft_ff) begin
			pwr_ff <= PWR_RST;
			osr_ff <= OSR_RST;
			odr_ff <= ODR_RST;
			cfg_ff <= CFG_RST;
		end else if (wr_ok) begin
			if (avm_req.address == ADR_PWR)
				pwr_ff <= new_en;
			if (avm_req.address == ADR_OSR)
				osr_ff <= avm_req.writedata[5:0];
			if (avm_req.address == ADR_ODR)
				odr_ff <= avm_req.writedata[4:0];
			if (wr_cfg)
				cfg_ff <= avm_req.writedata[6:0];
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			soft_ff <= 1'b0;
		else
			soft_ff <= wr_ok & (avm_req.address == ADR_CMD) &
				(avm_req.writedata[7:0] == SOFT_RST_CMD);
	end
	// Setting after a soft reset wins over a read clearing it.
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			por_ff <= POR_RST;
		else if (soft_ff)
			por_ff <= 1'b1;
		else if (rd_ok && avm_req.address == ADR_STATUS)
			por_ff <= 1'b0;
	end

////////////////////////////////////////////////////////////////////////////////
// Power-mode controller.
	assign busy = (seq_ff != S_IDLE);
	assign done = (seq_ff == S_DONE);
	assign tgt  = (avm_req.writedata[PWR_MODE_LSB +: 2] == 2'b00) ? M_SLEEP :
		(avm_req.writedata[PWR_MODE_LSB +: 2] == 2'b11) ? M_NORMAL : M_FORCED;

	always_comb begin
		nxt_mode  = mode_ff;
		nxt_pend  = pend_ff;
		nxt_pmode = pmode_ff;
		if (done) begin
			nxt_pend = 1'b0;
			if (pend_ff)
				nxt_mode = pmode_ff;
			else if (mode_ff == M_FORCED)
				nxt_mode = M_SLEEP;
		end
		// Only moves into or out of sleep are legal; normal to forced is not.
		if (wr_pwr && !pend_ff && ((nxt_mode == M_SLEEP) != (tgt == M_SLEEP))) begin
			if (busy && !done) begin
				nxt_pend  = 1'b1;
				nxt_pmode = tgt;
			end else begin
				nxt_mode = tgt;
			end
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_ff  <= M_SLEEP;
			pend_ff  <= 1'b0;
			pmode_ff <= M_SLEEP;
		end else if (soft_ff) begin
			mode_ff  <= M_SLEEP;
			pend_ff  <= 1'b0;
			pmode_ff <= M_SLEEP;
		end else begin
			mode_ff  <= nxt_mode;
			pend_ff  <= nxt_pend;
			pmode_ff <= nxt_pmode;
		end
	end
	// Sample period timer; a period overrunning its slot restarts at once.
	assign start = !busy && ((mode_ff == M_FORCED) ||
		(mode_ff == M_NORMAL && tmr_ff == 40'h0));
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			tmr_ff <= 40'h0;
		else if (soft_ff || mode_ff == M_SLEEP)
			tmr_ff <= 40'h0;
		else if (start)
			tmr_ff <= (40'(BASE_CYC) << odr_ff) - 40'h1;
		else if (tmr_ff != 40'h0)
			tmr_ff <= tmr_ff - 40'h1;
	end

////////////////////////////////////////////////////////////////////////////////
// Measurement sequencer.
	assign cur_osr = (seq_ff == S_TEMP) ? eff_osr(osr_ff[OSR_T_LSB +: 3]) :
		eff_osr(osr_ff[OSR_P_LSB +: 3]);
	assign cur_en  = (seq_ff == S_TEMP) ? pwr_ff[PWR_TEMP_BIT] : pwr_ff[PWR_PRESS_BIT];
	assign cur_smp = (seq_ff == S_TEMP) ? adc_smp.temp : adc_smp.press;
	assign sum     = acc_ff + RES_W'(cur_smp);
	// The sum of 2^n samples has 16+n bits; left align it to 21 bits.
	assign scaled  = RES_W'(sum << (OSR_MAX - cur_osr));
	assign meas_active = busy;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seq_ff   <= S_IDLE;
			acc_ff   <= '0;
			tick_ff  <= 16'h0;
			smp_ff   <= 6'h0;
			raw_t_ff <= '0;
			raw_p_ff <= '0;
		end else if (soft_ff) begin
			seq_ff  <= S_IDLE;
			acc_ff  <= '0;
			tick_ff <= 16'h0;
			smp_ff  <= 6'h0;
		end else begin
			case (seq_ff)
				S_IDLE: begin
					acc_ff  <= '0;
					tick_ff <= 16'h0;
					smp_ff  <= 6'h0;
					if (start)
						seq_ff <= S_TEMP;
				end
				S_TEMP, S_PRES: begin
					if (!cur_en) begin
						seq_ff <= (seq_ff == S_TEMP) ? S_PRES : S_DONE;
					end else if (tick_ff == 16'(CONV_CYC - 1)) begin
						tick_ff <= 16'h0;
						if (smp_ff == 6'((7'h1 << cur_osr) - 7'h1)) begin
							acc_ff <= '0;
							smp_ff <= 6'h0;
							if (seq_ff == S_TEMP)
								raw_t_ff <= scaled;
							else
								raw_p_ff <= scaled;
							seq_ff <= (seq_ff == S_TEMP) ? S_PRES : S_DONE;
						end else begin
							acc_ff <= sum;
							smp_ff <= smp_ff + 6'h1;
						end
					end else begin
						tick_ff <= tick_ff + 16'h1;
					end
				end
				S_DONE: seq_ff <= S_IDLE;
				default: seq_ff <= S_IDLE;
			endcase
		end
	end

////////////////////////////////////////////////////////////////////////////////
// IIR stage and result registers.
	assign clr_all = wr_cfg || (wr_pwr && ((pwr_ff & ~new_en) != 2'h0)) ||
		(mode_ff == M_SLEEP && nxt_mode == M_NORMAL);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			temp_ff  <= '0;
			press_ff <= '0;
			fv_t_ff  <= 1'b0;
			fv_p_ff  <= 1'b0;
		end else if (soft_ff) begin
			temp_ff  <= '0;
			press_ff <= '0;
			fv_t_ff  <= 1'b0;
			fv_p_ff  <= 1'b0;
		end else begin
			// A store in the clearing cycle wins; the clear is dropped and a valid memory still filters.
			if (done && pwr_ff[PWR_TEMP_BIT]) begin
				temp_ff <= fv_t_ff ? iir(temp_ff, raw_t_ff, cfg_ff) : raw_t_ff;
				fv_t_ff <= 1'b1;
			end else if (clr_all || (wr_pwr && new_en[PWR_TEMP_BIT])) begin
				fv_t_ff <= fv_t_ff & ~clr_all & pwr_ff[PWR_TEMP_BIT];
			end
			if (done && pwr_ff[PWR_PRESS_BIT]) begin
				press_ff <= fv_p_ff ? iir(press_ff, raw_p_ff, cfg_ff) : raw_p_ff;
				fv_p_ff  <= 1'b1;
			end else if (clr_all || (wr_pwr && new_en[PWR_PRESS_BIT])) begin
				fv_p_ff <= fv_p_ff & ~clr_all & pwr_ff[PWR_PRESS_BIT];
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Assertions.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	AST_MODE_DECODE: assert property (mode_ff == M_SLEEP && !busy && !soft_ff && wr_pwr &&
		avm_req.writedata[5:4] == 2'b11 |=> mode_ff == M_NORMAL)
		else $error("normal mode not entered from sleep");
	AST_SLEEP_IDLE: assert property (mode_ff == M_SLEEP && !busy |=> !busy)
		else $error("conversion started in sleep");
	AST_FORCED_BACK: assert property (done && mode_ff == M_FORCED && !soft_ff |=>
		mode_ff == M_SLEEP)
		else $error("forced mode did not return to sleep");
	AST_DEFER: assert property (busy && !done && !pend_ff && wr_pwr && !soft_ff &&
		mode_ff == M_NORMAL && tgt == M_SLEEP |=> pend_ff && mode_ff == M_NORMAL)
		else $error("mode change during measurement not deferred");
	AST_DISCARD: assert property (pend_ff && !done && !soft_ff |=>
		pmode_ff == $past(pmode_ff) && mode_ff == $past(mode_ff))
		else $error("pending mode change overwritten");
	AST_ILLEGAL: assert property (mode_ff == M_NORMAL && !pend_ff && !done && !soft_ff &&
		wr_pwr && tgt == M_FORCED |=> mode_ff == M_NORMAL && !pend_ff)
		else $error("illegal normal to forced change taken");
	AST_POR_CLEAR: assert property (rd_ok && avm_req.address == ADR_STATUS &&
		!soft_ff ##1 !soft_ff |-> !por_ff)
		else $error("power-on flag not cleared by read");
	AST_PRESS_SKIP: assert property (seq_ff == S_PRES && !pwr_ff[PWR_PRESS_BIT] &&
		!soft_ff |=> done ##1 press_ff == $past(press_ff))
		else $error("pressure converted while disabled");
	AST_NORMAL_RUN: assert property (mode_ff == M_NORMAL && !busy && tmr_ff == 40'h0 &&
		!soft_ff |=> seq_ff == S_TEMP)
		else $error("normal mode did not start a period");
	AST_FIRST_PASS: assert property (done && pwr_ff[PWR_TEMP_BIT] && !fv_t_ff &&
		!soft_ff |=> temp_ff == $past(raw_t_ff))
		else $error("first sample after filter reset was filtered");
	COV_FORCED: cover property (done && mode_ff == M_FORCED ##1 mode_ff == M_SLEEP);
	COV_NORMAL_TWICE: cover property (done && mode_ff == M_NORMAL && fv_p_ff);
	COV_DEFERRED: cover property (pend_ff && done ##1 !pend_ff);

endmodule

// ==== tb/pss_host.sv ====
// Host-side Avalon-MM master model for the sequencer bench.
// Assumes every call of its task starts just after a rising clock edge.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module pss_host
	import pss_pkg::*;
(
	// Clock
	input  wire logic             clk,
	// Register bus
	output pss_pkg::pss_avm_req_t avm_req,
	input  wire logic [31:0]      avm_readdata,
	input  wire logic             avm_waitrequest
);
	initial avm_req = '0;

	// The request stands until waitrequest is seen low; one idle edge follows.
	// That idle edge keeps a following call from driving the strobes twice at once.
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q, output logic ok);
		int n;
		ok = 1'b0;
		q = '0;
		avm_req <= '{address: a, read: !w, write: w, writedata: d};
		for (n = 0; n < 64 && !ok; n++) begin
			@(posedge clk);
			if (avm_waitrequest === 1'b0) begin
				ok = 1'b1;
				q = avm_readdata;
			end
		end
		avm_req.read <= 1'b0;
		avm_req.write <= 1'b0;
		@(posedge clk);
	endtask
endmodule

// ==== tb/pss_tb_top.sv ====
// Self-checking bench of the measurement sequencer with a host bus model.
// Assumes the base period parameter is shortened so normal mode runs quickly.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module pressure_sensor_measurement_sequencer_tb_top;
	import pss_pkg::*;
	localparam int unsigned BASE = 2000;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	pss_avm_req_t req;
	logic [31:0]  rdata;
	logic         wait_rq;
	pss_adc_t     adc = '0;
	logic         busy;
	int           failures = 0;
	int           checks_done = 0;
	int           seed = 65;
	logic [31:0]  q;
	logic         ok;
	logic [15:0]  sa;
	logic [15:0]  sb;
	logic [20:0]  fp;
	int           n;

	always #2 clk = ~clk;

	pss_host host (.clk(clk), .avm_req(req), .avm_readdata(rdata), .avm_waitrequest(wait_rq));
	pss_sequencer #(.BASE_CYC(BASE)) dut (.clk(clk), .rst(rst), .avm_req(req),
		.avm_readdata(rdata), .avm_waitrequest(wait_rq), .adc_smp(adc), .meas_active(busy));

	task automatic stop_test();
		$display("checks_done %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	function automatic int rnd(input int m);
		return ($random(seed) & 32'h7fffffff) % m;
	endfunction

	// Data words carry the 21-bit result left of three zero bits.
	function automatic logic [31:0] fw(input logic [20:0] r);
		return {8'h00, r, 3'b000};
	endfunction

	function automatic logic [20:0] iir(input logic [20:0] o, input logic [20:0] nw, input int c);
		return 21'((32'(o) * c + 32'(nw)) / (c + 1));
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(a, 1'b1, d, q, ok);
		if (!ok) begin
			failures++;
			stop_test();
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		host.xfer(a, 1'b0, 32'h0, q, ok);
		if (!ok) begin
			failures++;
			stop_test();
		end
		chk32(q & m, e);
	endtask

	task automatic to_lvl(input logic v, input int lim);
		int k;
		for (k = 0; k < lim && busy !== v; k++) @(posedge clk);
		if (busy !== v) begin
			failures++;
			stop_test();
		end
	endtask

	task automatic shot(input logic [31:0] pwr, input int lim);
		wr(ADR_PWR, pwr);
		to_lvl(1'b1, 20);
		to_lvl(1'b0, lim);
	endtask

	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd_chk(ADR_STATUS, 32'h1f, 32'h01);
		rd_chk(ADR_STATUS, 32'h01, 32'h00);
		for (n = 1; n < 5; n++) rd_chk(8'(n * 4), 32'hffffffff, 32'h0);
		wr(8'h20, 32'h5);
		rd_chk(8'h20, 32'hffffffff, 32'h0);
		n = rnd(6) + 8 * rnd(6);
		wr(ADR_OSR, 32'(n));
		rd_chk(ADR_OSR, 32'h3f, 32'(n));
		chk32({31'h0, busy}, 32'h0);
		for (int k = 1; k < 3; k++) begin
			sa = 16'(rnd(65536));
			sb = 16'(rnd(65536));
			adc <= '{temp: sa, press: sb};
			wr(ADR_OSR, 32'(rnd(3) + 8 * rnd(3)));
			shot(32'(k * 16 + 3), 20000);
			rd_chk(ADR_STATUS, 32'h06, 32'h0);
			rd_chk(ADR_PRESS, 32'hffffffff, fw({sb, 5'h0}));
			rd_chk(ADR_TEMP, 32'hffffffff, fw({sa, 5'h0}));
		end
		adc <= '{temp: 16'(rnd(65536)), press: 16'(rnd(65536))};
		wr(ADR_OSR, 32'h05);
		shot(32'h11, 20000);
		rd_chk(ADR_PRESS, 32'hffffffff, fw({adc.press, 5'h0}));
		rd_chk(ADR_TEMP, 32'hffffffff, fw({sa, 5'h0}));
		sb = adc.press;
		adc <= '{temp: 16'(rnd(65536)), press: 16'(rnd(65536))};
		shot(32'h12, 20000);
		rd_chk(ADR_TEMP, 32'hffffffff, fw({adc.temp, 5'h0}));
		rd_chk(ADR_PRESS, 32'hffffffff, fw({sb, 5'h0}));
		wr(ADR_CFG, 32'h7f);
		rd_chk(ADR_CFG, 32'hffffffff, 32'h7f);
		wr(ADR_CFG, 32'h01);
		wr(ADR_OSR, 32'h0);
		sa = 16'(rnd(65536));
		adc <= '{temp: sa, press: sa};
		shot(32'h13, 5000);
		rd_chk(ADR_PRESS, 32'hffffffff, fw({sa, 5'h0}));
		sb = 16'(rnd(65536));
		adc <= '{temp: sb, press: sb};
		shot(32'h13, 5000);
		fp = iir({sa, 5'h0}, {sb, 5'h0}, 1);
		rd_chk(ADR_PRESS, 32'hffffffff, fw(fp));
		rd_chk(ADR_TEMP, 32'hffffffff, fw(fp));
		// Normal mode: period measured between two measurement starts.
		wr(ADR_ODR, 32'h01);
		sa = 16'(rnd(65536));
		adc <= '{temp: sa, press: sa};
		wr(ADR_PWR, 32'h33);
		rd_chk(ADR_STATUS, 32'h06, 32'h06);
		to_lvl(1'b1, 5000);
		to_lvl(1'b0, 5000);
		to_lvl(1'b1, 5000);
		n = 0;
		while (busy === 1'b1 && n < 9000) begin
			@(posedge clk);
			n++;
		end
		while (busy !== 1'b1 && n < 9000) begin
			@(posedge clk);
			n++;
		end
		chk32(32'(n), 32'(BASE << 1));
		to_lvl(1'b0, 5000);
		rd_chk(ADR_PRESS, 32'hffffffff, fw({sa, 5'h0}));
		sb = 16'(rnd(65536));
		adc <= '{temp: sb, press: sb};
		to_lvl(1'b1, 5000);
		to_lvl(1'b0, 5000);
		rd_chk(ADR_PRESS, 32'hffffffff, fw(iir({sa, 5'h0}, {sb, 5'h0}, 1)));
		wr(ADR_PWR, 32'h13);
		rd_chk(ADR_STATUS, 32'h06, 32'h06);
		to_lvl(1'b1, 5000);
		wr(ADR_PWR, 32'h03);
		rd_chk(ADR_STATUS, 32'h10, 32'h10);
		wr(ADR_PWR, 32'h33);
		to_lvl(1'b0, 5000);
		rd_chk(ADR_STATUS, 32'h16, 32'h0);
		n = 0;
		for (int k = 0; k < 4100; k++) begin
			@(posedge clk);
			if (busy !== 1'b0) n++;
		end
		chk32(32'(n), 32'h0);
		wr(ADR_CMD, 32'(SOFT_RST_CMD));
		repeat (2) @(posedge clk);
		rd_chk(ADR_STATUS, 32'h1f, 32'h01);
		rd_chk(ADR_CFG, 32'hffffffff, 32'h0);
		stop_test();
	end
endmodule
